// [design/abgs_top.sv]
// Purpose: Aux input gating and aux output selection of a bit-error detector
// Assumes: One received bit per core_clk_in cycle; APB slave with one wait state
// Notes: Threshold and phase search is left to software
`timescale 1ns/1ns
`default_nettype none
`include "abgs_defines.svh"
module abgs_top #(
	parameter int DLY_DEPTH = 1024,
	parameter int ROW_BITS = 128,
	parameter int ROWS = 16,
	parameter int ERR_HOLD = 16
) (
	input wire logic core_clk_in, // Recovered bit clock
	input wire logic reset_in, // Sync reset, active high
	input wire logic ce_in, // Clock enable, freezes all
	input wire logic [7:0] paddr_in, // APB address
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB write
	input wire logic [31:0] pwdata_in, // APB write data
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error, unmapped
	input wire logic aux_pin_in, // Aux timing pin
	input wire logic bit_vld_in, // Received bit this cycle
	input wire logic bit_err_in, // Received bit in error
	input wire logic pat_start_in, // Pattern period start
	input wire logic sync_ok_in, // Pattern sync held
	output logic bit_cnt_en_out, // Bit counted
	output logic err_cnt_en_out, // Error counted
	output logic cap_trig_out, // Capture start pulse
	output logic aux_out, // Aux output pin
	output logic irq_out // Interrupt level
);
	import abgs_pkg::*;

	localparam int DW = $clog2(DLY_DEPTH);
	localparam int EW = $clog2(ERR_HOLD + 1);

	logic [7:0] ctrl_q;
	logic [31:0] enlen_q;
	logic [31:0] dly_k_q;
	logic [9:0] divn_q;
	logic [31:0] plen_q;
	logic [31:0] mpos_q;
	logic [15:0] mix_q;
	logic [`ABGS_NEV-1:0] sts_q;
	logic [`ABGS_NEV-1:0] mask_q;
	logic [31:0] bits_q;
	logic [31:0] errs_q;
	logic [31:0] ext_q;
	abgs_ext_st_t ext_st_q;
	abgs_in_mode_t in_mode;
	abgs_out_sel_t out_sel;
	logic paired;
	logic aux_s;
	logic aux_rise;
	logic acc;
	logic wr;
	logic rdy_q;
	logic [31:0] rd_c;
	logic unmapped;

	assign in_mode = abgs_in_mode_t'(ctrl_q[`ABGS_F_INMODE]);
	assign out_sel = abgs_out_sel_t'(ctrl_q[`ABGS_F_OUTSEL]);
	assign paired = ctrl_q[`ABGS_F_PAIRED];

	// Pin crossing
	abgs_sync3 u_sync (
		.clk_in(core_clk_in),
		.rst_in(reset_in),
		.ce_in(ce_in),
		.async_in(aux_pin_in),
		.level_out(aux_s),
		.rise_out(aux_rise)
	);

	// APB handshake: one wait state gives time to register read data
	assign acc = psel_in && penable_in;
	assign pready_out = ce_in && rdy_q;
	assign wr = acc && pwrite_in && pready_out;
	assign pslverr_out = pready_out && unmapped;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			rdy_q <= 1'b0;
		end else if (ce_in) begin
			rdy_q <= acc && !rdy_q;
		end
	end

	// Gate delay line, one bit per received bit
	logic dly_mem [DLY_DEPTH];
	logic [DW-1:0] wp_q;
	logic [31:0] dly_full;
	logic [DW-1:0] dly_use;
	logic gate_lvl;
	logic gate_prev_q;
	logic gate_rise;
	assign dly_full = paired ? {dly_k_q[27:0], 4'h0} : {dly_k_q[28:0], 3'h0};
	// Delays past the line depth clamp rather than wrap
	assign dly_use = !ctrl_q[`ABGS_F_MANDLY] ? '0 :
		(dly_full > 32'(DLY_DEPTH - 1)) ? DW'(DLY_DEPTH - 1) : dly_full[DW-1:0];
	assign gate_lvl = (dly_use == '0) ? aux_s : dly_mem[wp_q - dly_use];
	assign gate_rise = gate_lvl && !gate_prev_q;
	always_ff @(posedge core_clk_in) begin
		if (ce_in) begin
			dly_mem[wp_q] <= aux_s;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			wp_q <= '0;
			gate_prev_q <= 1'b0;
		end else if (ce_in) begin
			wp_q <= wp_q + 1'b1;
			gate_prev_q <= gate_lvl;
		end
	end

	// Window counter and idle-gap watch
	logic [31:0] win_q;
	logic [31:0] gap_q;
	logic seen_q;
	logic win_open;
	logic win_start;
	logic gap_viol;
	assign win_open = win_q != 32'h0000_0000;
	assign win_start = (in_mode == in_window) && gate_rise && !win_open;
	assign gap_viol = win_start && seen_q &&
		(gap_q < (paired ? `ABGS_GAP2 : `ABGS_GAP1));
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			win_q <= '0;
			gap_q <= '0;
			seen_q <= 1'b0;
		end else if (ce_in) begin
			if (win_start) begin
				win_q <= enlen_q;
				seen_q <= 1'b1;
			end else if (win_open) begin
				win_q <= win_q - 1'b1;
			end
			if (win_open) begin
				gap_q <= '0;
			end else if (gap_q != 32'hFFFF_FFFF) begin
				gap_q <= gap_q + 1'b1;
			end
		end
	end

	// Validity of the current bit per input mode
	logic valid_c;
	always_comb begin
		case (in_mode)
			in_window: valid_c = win_open;
			in_level: valid_c = gate_lvl;
			in_mask: valid_c = gate_lvl;
			default: valid_c = 1'b1;
		endcase
	end

	// Counting enables and totals
	logic bit_en_q;
	logic err_en_q;
	logic err_c;
	assign err_c = bit_vld_in && bit_err_in && valid_c;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			bit_en_q <= 1'b0;
			err_en_q <= 1'b0;
			bits_q <= '0;
			errs_q <= '0;
		end else if (ce_in) begin
			bit_en_q <= bit_vld_in && valid_c;
			err_en_q <= err_c;
			if (bit_vld_in && valid_c) begin
				bits_q <= bits_q + 1'b1;
			end
			if (err_c) begin
				errs_q <= errs_q + 1'b1;
			end
		end
	end
	assign bit_cnt_en_out = bit_en_q;
	assign err_cnt_en_out = err_en_q;

	// Capture trigger uses the undelayed edge
	logic cap_q;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			cap_q <= 1'b0;
		end else if (ce_in) begin
			cap_q <= ctrl_q[`ABGS_F_CAPEXT] && aux_rise;
		end
	end
	assign cap_trig_out = cap_q;

	// Divided clock restarts at each pattern start to stay aligned
	logic [8:0] div_cnt_q;
	logic div_clk_q;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			div_cnt_q <= '0;
			div_clk_q <= 1'b0;
		end else if (ce_in) begin
			if (pat_start_in) begin
				div_cnt_q <= '0;
				div_clk_q <= 1'b1;
			end else if (div_cnt_q >= divn_q[9:1] - 1'b1) begin // A lowered ratio cannot stall on a wrap
				div_cnt_q <= '0;
				div_clk_q <= !div_clk_q;
			end else begin
				div_cnt_q <= div_cnt_q + 1'b1;
			end
		end
	end

	// Extended length grows by whole multiples of the set length
	logic [31:0] ext_min;
	logic grow_go;
	assign ext_min = paired ? `ABGS_EXT_MIN2 : `ABGS_EXT_MIN1;
	assign grow_go = wr && ((paddr_in == `ABGS_PLEN_OFS) || (paddr_in == `ABGS_CTRL_OFS));
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ext_q <= `ABGS_PLEN_RST;
			ext_st_q <= ext_idle;
		end else if (ce_in) begin
			case (ext_st_q)
				ext_idle: begin
					if (grow_go) begin
						ext_q <= (paddr_in == `ABGS_PLEN_OFS) ? pwdata_in : plen_q;
						ext_st_q <= ext_grow;
					end
				end
				ext_grow: begin
					// A write during growth restarts it, so the new length is never lost
					if (grow_go) begin
						ext_q <= (paddr_in == `ABGS_PLEN_OFS) ? pwdata_in : plen_q;
					end else if (ext_q >= ext_min || plen_q == 32'h0000_0000) begin
						ext_st_q <= ext_idle;
					end else begin
						ext_q <= ext_q + plen_q;
					end
				end
				default: ext_st_q <= ext_idle;
			endcase
		end
	end

	// Marker position and its allowed range
	logic [2:0] tz_c;
	logic [39:0] lcm_c;
	logic [39:0] mix_pos;
	logic [39:0] mark_pos;
	logic [39:0] cur_pos;
	logic [39:0] pos_q;
	logic pos_bad;
	logic mark_c;
	logic mark_q;
	always_comb begin
		tz_c = `ABGS_LCM_SH;
		for (int i = 6; i >= 0; i--) begin
			if (ext_q[i]) begin
				tz_c = 3'(i);
			end
		end
	end
	assign lcm_c = {8'h00, ext_q} << (`ABGS_LCM_SH - tz_c);
	assign mix_pos = 40'((32'(mix_q[15:8]) * ROWS + 32'(mix_q[7:0])) * ROW_BITS) + 1'b1;
	assign mark_pos = ctrl_q[`ABGS_F_MIXED] ? mix_pos :
		paired ? {4'h0, mpos_q, 4'h0} + 1'b1 : {5'h00, mpos_q, 3'h0} + 1'b1;
	// A position past the period end would fire never or twice, so outside mixed mode it is blocked
	assign pos_bad = (ext_st_q != ext_idle) || (!ctrl_q[`ABGS_F_MIXED] &&
		(mark_pos > lcm_c - (paired ? `ABGS_TAIL2 : `ABGS_TAIL1)));
	assign cur_pos = pat_start_in ? 40'h00_0000_0001 : pos_q + 1'b1;
	assign mark_c = (cur_pos == mark_pos) && !pos_bad;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			pos_q <= '0;
			mark_q <= 1'b0;
		end else if (ce_in) begin
			pos_q <= cur_pos;
			mark_q <= mark_c;
		end
	end

	// Error output holds a few bits so slow equipment sees it
	logic [EW-1:0] errh_q;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			errh_q <= '0;
		end else if (ce_in) begin
			if (err_c) begin
				errh_q <= EW'(ERR_HOLD);
			end else if (errh_q != '0) begin
				errh_q <= errh_q - 1'b1;
			end
		end
	end

	// Aux output selection
	logic aux_q;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			aux_q <= 1'b0;
		end else if (ce_in) begin
			case (out_sel)
				out_div: aux_q <= div_clk_q;
				out_mark: aux_q <= mark_c;
				out_lock: aux_q <= sync_ok_in;
				out_err: aux_q <= err_c || (errh_q != '0);
				default: aux_q <= 1'b0;
			endcase
		end
	end
	assign aux_out = aux_q;

	// Sticky status; a read clears only the bits it returned, so set wins
	logic [`ABGS_NEV-1:0] ev;
	logic sts_rd;
	assign ev = {gap_viol, err_c, ctrl_q[`ABGS_F_CAPEXT] && aux_rise, win_start, mark_c};
	assign sts_rd = acc && !pwrite_in && pready_out && (paddr_in == `ABGS_STS_OFS);
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			sts_q <= '0;
		end else if (ce_in) begin
			sts_q <= (sts_q & ~(sts_rd ? prdata_out[`ABGS_NEV-1:0] : '0)) | ev;
		end
	end
	assign irq_out = |(sts_q & mask_q);

	// Register writes; bad divide ratios are refused
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ctrl_q <= `ABGS_CTRL_RST;
			enlen_q <= `ABGS_ENLEN_RST;
			dly_k_q <= '0;
			divn_q <= `ABGS_DIVN_RST;
			plen_q <= `ABGS_PLEN_RST;
			mpos_q <= '0;
			mix_q <= '0;
			mask_q <= '0;
		end else if (wr) begin
			case (paddr_in)
				`ABGS_CTRL_OFS: ctrl_q <= pwdata_in[7:0];
				`ABGS_ENLEN_OFS: enlen_q <= pwdata_in;
				`ABGS_DLY_OFS: dly_k_q <= pwdata_in;
				`ABGS_DIVN_OFS: begin
					if (!pwdata_in[0] && pwdata_in[31:10] == 22'h00_0000 &&
						pwdata_in[9:0] >= `ABGS_DIVN_MIN &&
						pwdata_in[9:0] <= `ABGS_DIVN_MAX) begin
						divn_q <= pwdata_in[9:0];
					end
				end
				`ABGS_PLEN_OFS: plen_q <= pwdata_in;
				`ABGS_MPOS_OFS: mpos_q <= pwdata_in;
				`ABGS_MIX_OFS: mix_q <= pwdata_in[15:0];
				`ABGS_MASK_OFS: mask_q <= pwdata_in[`ABGS_NEV-1:0];
				default: ;
			endcase
		end
	end

	// Read mux and decode
	always_comb begin
		rd_c = '0;
		unmapped = 1'b0;
		case (paddr_in)
			`ABGS_CTRL_OFS: rd_c[7:0] = ctrl_q;
			`ABGS_ENLEN_OFS: rd_c = enlen_q;
			`ABGS_DLY_OFS: rd_c = dly_k_q;
			`ABGS_DIVN_OFS: rd_c[9:0] = divn_q;
			`ABGS_PLEN_OFS: rd_c = plen_q;
			`ABGS_MPOS_OFS: rd_c = mpos_q;
			`ABGS_MIX_OFS: rd_c[15:0] = mix_q;
			`ABGS_STS_OFS: begin
				rd_c[`ABGS_NEV-1:0] = sts_q;
				rd_c[`ABGS_S_AUX] = aux_s;
				rd_c[`ABGS_S_POSBAD] = pos_bad;
				rd_c[`ABGS_S_EXTBUSY] = ext_st_q != ext_idle;
			end
			`ABGS_MASK_OFS: rd_c[`ABGS_NEV-1:0] = mask_q;
			`ABGS_BITS_OFS: rd_c = bits_q;
			`ABGS_ERRS_OFS: rd_c = errs_q;
			`ABGS_EXT_OFS: rd_c = ext_q;
			default: unmapped = 1'b1;
		endcase
	end
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			prdata_out <= '0;
		end else if (ce_in && acc && !rdy_q && !pwrite_in) begin
			prdata_out <= rd_c;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	a_div_ratio_legal: assert property (
		!divn_q[0] && divn_q >= `ABGS_DIVN_MIN && divn_q <= `ABGS_DIVN_MAX)
		else $error("divide ratio out of range");
	a_div_aligned: assert property (
		ce_in && pat_start_in |=> div_cnt_q == 9'h000 && div_clk_q)
		else $error("divided clock not aligned");
	a_window_open: assert property (
		ce_in && win_start && enlen_q > 32'h0000_0002 ##1 ce_in |=> win_open)
		else $error("window closed early");
	a_level_gate: assert property (
		ce_in && in_mode == in_level && !gate_lvl |=> !bit_cnt_en_out && !err_cnt_en_out)
		else $error("bit counted outside level gate");
	a_mask_gate: assert property (
		ce_in && in_mode == in_mask && !gate_lvl |=> !bit_cnt_en_out)
		else $error("bit counted while masked");
	a_no_count_out: assert property (
		bit_cnt_en_out && $past(ce_in) |-> $past(bit_vld_in) && $past(valid_c))
		else $error("invalid bit counted");
	a_cap_cause: assert property (
		cap_trig_out && $past(ce_in) |-> $past(aux_rise) && $past(ctrl_q[`ABGS_F_CAPEXT]))
		else $error("capture trigger without cause");
	a_lock_follow: assert property (
		ce_in && out_sel == out_lock ##1 ce_in |-> aux_out == $past(sync_ok_in))
		else $error("lock output wrong");
	a_err_show: assert property (
		ce_in && err_c && out_sel == out_err |=> aux_out [*2])
		else $error("error output not high");
	a_mark_pos: assert property (
		mark_q && $past(ce_in) |-> $past(cur_pos) == $past(mark_pos) && !$past(pos_bad))
		else $error("marker at wrong position");
	a_ext_min: assert property (
		$fell(ext_st_q == ext_grow) && plen_q != 32'h0000_0000 |-> ext_q >= ext_min)
		else $error("extended length too short");
	a_gap_flag: assert property (
		ce_in && gap_viol |=> sts_q[`ABGS_S_GAP])
		else $error("gap violation not flagged");

	c_window: cover property (win_start ##[1:20] !win_open);
	c_marker: cover property (out_sel == out_mark && mark_q);
	c_sts_read: cover property (sts_rd && sts_q != '0);
	c_err_out: cover property (out_sel == out_err && aux_out);
endmodule : abgs_top
`default_nettype wire

// [design/abgs_defines.svh]
// Purpose: Register map, field positions, reset values and limits
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Definitions only, included by bare name
`ifndef ABGS_DEFINES_SVH
`define ABGS_DEFINES_SVH

// Register byte offsets
`define ABGS_CTRL_OFS 8'h00
`define ABGS_ENLEN_OFS 8'h04
`define ABGS_DLY_OFS 8'h08
`define ABGS_DIVN_OFS 8'h0C
`define ABGS_PLEN_OFS 8'h10
`define ABGS_MPOS_OFS 8'h14
`define ABGS_MIX_OFS 8'h18
`define ABGS_STS_OFS 8'h1C
`define ABGS_MASK_OFS 8'h20
`define ABGS_BITS_OFS 8'h24
`define ABGS_ERRS_OFS 8'h28
`define ABGS_EXT_OFS 8'h2C

// Control field positions
`define ABGS_F_INMODE 1:0
`define ABGS_F_OUTSEL 3:2
`define ABGS_F_PAIRED 4
`define ABGS_F_CAPEXT 5
`define ABGS_F_MIXED 6
`define ABGS_F_MANDLY 7

// Status field positions
`define ABGS_S_MARK 0
`define ABGS_S_WIN 1
`define ABGS_S_CAP 2
`define ABGS_S_ERR 3
`define ABGS_S_GAP 4
`define ABGS_S_AUX 8
`define ABGS_S_POSBAD 9
`define ABGS_S_EXTBUSY 10
`define ABGS_NEV 5

// Reset values
`define ABGS_CTRL_RST 8'h00
`define ABGS_ENLEN_RST 32'h0000_3200
`define ABGS_DIVN_RST 10'h040
`define ABGS_PLEN_RST 32'h0000_7FFF

// Limits in bits
`define ABGS_DIVN_MIN 10'h004
`define ABGS_DIVN_MAX 10'h200
`define ABGS_EXT_MIN1 32'h0000_0200
`define ABGS_EXT_MIN2 32'h0000_0400
`define ABGS_TAIL1 40'h00_0000_0087
`define ABGS_TAIL2 40'h00_0000_010F
`define ABGS_GAP1 32'h0000_0200
`define ABGS_GAP2 32'h0000_0400
`define ABGS_LCM_SH 3'h7

`endif

// [design/abgs_pkg.sv]
// Purpose: Types shared by the aux gate and sync-out logic
// Assumes: Codes of the mode enums match the control fields
// Notes: Constants live in abgs_defines.svh
`default_nettype none
package abgs_pkg;
	typedef enum logic [1:0] {in_none, in_window, in_level, in_mask} abgs_in_mode_t;
	typedef enum logic [1:0] {out_div, out_mark, out_lock, out_err} abgs_out_sel_t;
	typedef enum logic {ext_idle, ext_grow} abgs_ext_st_t;
endpackage : abgs_pkg
`default_nettype wire

// [design/abgs_sync3.sv]
// Purpose: Three-stage synchroniser for the aux timing pin
// Assumes: Pin is asynchronous to the bit clock
// Notes: Level changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module abgs_sync3 (
	input wire logic clk_in, // Bit clock
	input wire logic rst_in, // Sync reset, active high
	input wire logic ce_in, // Clock enable
	input wire logic async_in, // Raw pin level
	output logic level_out, // Filtered level
	output logic rise_out // One-cycle rising edge
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	logic rise_q;

	// Stage one feeds only stage two, so metastability stays contained
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
			rise_q <= 1'b0;
		end else if (ce_in) begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
			rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
		end
	end

	assign level_out = lvl_q;
	assign rise_out = rise_q;
endmodule : abgs_sync3
`default_nettype wire

// [verification/abgs_aux_src.sv]
// Purpose: Model of the external timing source on the aux pin
// Assumes: Bench calls one burst at a time, right after a clock edge
// Notes: The idle gap is always kept, so no window overlaps the next
`timescale 1ns/1ns
`default_nettype none
module abgs_aux_src #(
	parameter int GAP = 512 // Idle bits after each burst
) (
	input wire logic clk_in, // Bit clock
	output logic pin_out // Aux timing pin
);
	// Driven low while idle, so a closed window never floats
	initial pin_out = 1'b0;

	// One burst: high for the given bits, then the idle gap
	task automatic burst(input int bits);
		pin_out <= 1'b1;
		repeat (bits) @(posedge clk_in);
		pin_out <= 1'b0;
		repeat (GAP) @(posedge clk_in);
	endtask : burst
endmodule : abgs_aux_src
`default_nettype wire

// [verification/test_aux_burst_gate_and_sync_out.sv]
// Purpose: Self-checking bench for the aux gate and sync-out block
// Assumes: APB slave answers after one wait state; short delay line and error hold
// Notes: Reads are noted in a queue and checked by the APB monitor
`timescale 1ns/1ns
`default_nettype none
`include "abgs_defines.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module test_aux_burst_gate_and_sync_out;
	localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
	logic clk, rst, psel, pen, pwr, pready, perr, aux_pin, vld, err, pst, sync;
	logic bcen, ecen, cap, aux, irq, lockchk, sp, pa, pp, pb;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [32:0] eq[$], mq[$], got;
	int bad_count, n_checks, nb, ne, nc, nr, nh, cyc, tp, dpos, pat_per, pc, tmo;
	int b0, e0, c0, h0, r0, fp, fb, lat0;
	int dv[5] = '{4, 5, 6, 514, 512};
	int de[5] = '{4, 4, 6, 6, 512};
	int mp[6] = '{0, 0, 0, 1, 1, 2};
	int mk[6] = '{3, 111, 112, 47, 48, 2};
	// Per marker kind (single, paired, mixed): step, first refused index, control word
	int stp[3] = '{8, 16, 128};
	int lim[3] = '{112, 48, 16};
	logic [31:0] mc[3] = '{32'h0000_0004, 32'h0000_0014, 32'h0000_0044};

	abgs_top #(.DLY_DEPTH(64), .ERR_HOLD(4)) DUT (.core_clk_in(clk), .reset_in(rst),
		.ce_in(1'b1), .paddr_in(paddr), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(perr), .aux_pin_in(aux_pin), .bit_vld_in(vld), .bit_err_in(err),
		.pat_start_in(pst), .sync_ok_in(sync), .bit_cnt_en_out(bcen),
		.err_cnt_en_out(ecen), .cap_trig_out(cap), .aux_out(aux), .irq_out(irq));
	abgs_aux_src src (.clk_in(clk), .pin_out(aux_pin));

	// Bench clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// One APB transfer; a clear cycle follows so no signal is set twice at one edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
		eq.push_back(e);
		mq.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	// Pattern period starts; period 0 keeps the line quiet
	always @(posedge clk) begin
		if (pat_per != 0) begin
			pc <= (pc + 1 >= pat_per) ? 0 : pc + 1;
			pst <= (pc == 0);
		end else begin
			pst <= 1'b0;
		end
	end

	// APB read checker and hang guard, sampled at the edge that completes a read
	always @(posedge clk) begin
		if (psel === 1'b1 && pen === 1'b1 && pready === 1'b1 && pwr === 1'b0) begin
			got = {perr, prdata} & mq[0];
			`CHK(got, eq[0])
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
		tmo++;
		if (tmo == 50000) begin
			bad_count++;
			summarize();
		end
	end

	// Output counters on the falling edge, where outputs have settled
	always @(negedge clk) begin
		cyc++;
		nb += (bcen === 1'b1);
		ne += (ecen === 1'b1);
		nc += (cap === 1'b1);
		nh += (aux === 1'b1);
		if (aux_pin === 1'b1 && pp !== 1'b1) fp = cyc;
		if (bcen === 1'b1 && pb !== 1'b1) fb = cyc;
		if (pst === 1'b1) tp = cyc;
		if (aux === 1'b1 && pa !== 1'b1) begin
			nr++;
			dpos = cyc - tp;
		end
		if (lockchk === 1'b1) `CHK(aux, sp)
		sp = sync;
		pa = aux;
		pp = aux_pin;
		pb = bcen;
	end

	initial begin
		rst = 1'b1;
		{psel, pen, pwr, vld, err, pst, sync, lockchk} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rnd = 32'h0000_0048;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		vld <= 1'b1;
		@(posedge clk);
		rd(`ABGS_CTRL_OFS, 33'h0_0000_0000, ALL);
		rd(`ABGS_ENLEN_OFS, 33'h0_0000_3200, ALL);
		rd(`ABGS_DIVN_OFS, 33'h0_0000_0040, ALL);
		rd(`ABGS_PLEN_OFS, 33'h0_0000_7FFF, ALL);
		rd(8'h30, 33'h1_0000_0000, ALL);
		apb(1'b1, `ABGS_ENLEN_OFS, 32'h0000_0014);
		apb(1'b1, `ABGS_MASK_OFS, 32'h0000_0004);
		apb(1'b1, `ABGS_DLY_OFS, 32'h0000_0002);
		// Window, level, mask and delayed level gating with one 30-bit burst each
		for (int m = 1; m < 5; m++) begin
			apb(1'b1, `ABGS_CTRL_OFS, (m == 4) ? 32'h0000_0082 :
				32'(m) | ((m == 1) ? 32'h0000_0020 : 32'h0000_0000));
			err <= 1'b1;
			repeat (3) @(posedge clk);
			b0 = nb;
			e0 = ne;
			c0 = nc;
			src.burst(30);
			// Two delay steps move the first counted bit by 16 against plain level mode
			if (m == 2) lat0 = fb - fp;
			if (m == 4) `CHK(fb - fp - lat0, 16)
			`CHK(nb - b0, (m == 1) ? 20 : 30)
			`CHK(ne - e0, nb - b0)
			`CHK(nc - c0, (m == 1) ? 1 : 0)
			`CHK(irq, (m == 1) ? 1'b1 : 1'b0)
			rd(`ABGS_STS_OFS, {1'b0, 32'(m == 1) << 2}, 33'h0_0000_0004);
			`CHK(irq, 1'b0)
		end
		err <= 1'b0;
		// Error output: one bad bit gives one hold pulse
		apb(1'b1, `ABGS_CTRL_OFS, 32'h0000_000C);
		repeat (8) @(posedge clk);
		h0 = nh;
		err <= 1'b1;
		@(posedge clk);
		err <= 1'b0;
		repeat (12) @(posedge clk);
		`CHK(nh - h0, 5)
		// Lock output follows random sync
		apb(1'b1, `ABGS_CTRL_OFS, 32'h0000_0008);
		repeat (2) @(posedge clk);
		lockchk <= 1'b1;
		repeat (64) begin
			rnd = xs(rnd);
			sync <= rnd[0];
			@(posedge clk);
		end
		lockchk <= 1'b0;
		// Divided clock, refused ratios keep the old one
		apb(1'b1, `ABGS_CTRL_OFS, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `ABGS_DIVN_OFS, 32'(dv[i]));
			rd(`ABGS_DIVN_OFS, {1'b0, 32'(de[i])}, ALL);
			repeat (8) @(posedge clk);
			r0 = nr;
			repeat (3072) @(posedge clk);
			`CHK(nr - r0, 3072 / de[i])
		end
		// Short pattern grows to 600 single, 1100 paired
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, `ABGS_CTRL_OFS, 32'(p) << 4);
			apb(1'b1, `ABGS_PLEN_OFS, 32'h0000_0064);
			repeat (30) @(posedge clk);
			rd(`ABGS_EXT_OFS, (p == 1) ? 33'h0_0000_044C : 33'h0_0000_0258, ALL);
		end
		// Marker at boundary positions and one mixed row, 1024-bit pattern period
		pat_per <= 1024;
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `ABGS_CTRL_OFS, mc[mp[i]]);
			apb(1'b1, (mp[i] == 2) ? `ABGS_MIX_OFS : `ABGS_MPOS_OFS, 32'(mk[i]));
			apb(1'b1, `ABGS_PLEN_OFS, 32'h0000_0400);
			repeat (1024) @(posedge clk);
			r0 = nr;
			repeat (2048) @(posedge clk);
			`CHK(nr - r0, (mk[i] < lim[mp[i]]) ? 2 : 0)
			if (nr != r0) `CHK(dpos, mk[i] * stp[mp[i]] + 1)
		end
		repeat (4) @(posedge clk);
		if (eq.size() != 0) bad_count++;
		summarize();
	end
endmodule : test_aux_burst_gate_and_sync_out
`default_nettype wire
